/* File: logic/data_space_access_unit.sv */
// Program counter, vector and data space access logic of the core
//
// Behaviour
// - Program word is low word plus upper byte
// - PC stays even, steps by two
// - Reset starts at 0, target at 2
// - Vector tables below 0x200, primary and alternate
// - Data addresses are 16-bit byte addresses
// - Address bit 15 selects visibility window
// - Reads beyond implemented RAM return zero
// - Low byte even address, high odd
// - Pointer steps one for byte, two word
// - Byte read picks lane onto low byte
// - Shared word decode, separate byte strobes
// - Odd word access raises address error
// - Misaligned read completes, misaligned write suppressed
// - Byte load keeps register high byte
// - Sign and zero extend of byte
// - SPECIAL_FUNCTION_REGISTER region; unused addresses read zero
// - Near region reached by 13-bit field
// - Whole space by 16-bit direct or pointer
// - X and Y words read together
// - X read bus serves unified reads
// - Modulo both spaces, bit-reverse X writes
// - Writes unified; fixed X/Y boundary
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit #(
   parameter int RAM_BYTES = data_space_pkg::RAM_BYTES_DEF,
   parameter logic [15:0] Y_BASE = data_space_pkg::Y_BASE_DEF
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Program sequencing
   input wire logic pc_step_i,
   input wire logic pc_load_i,
   input wire logic [23:0] pc_target_i,
   input wire logic vec_take_i,
   input wire logic vec_alt_i,
   input wire logic [data_space_pkg::VEC_NUM_W-1:0] vec_num_i,
   input wire logic fetch_valid_i,
   input wire logic [15:0] prog_lo_i,
   input wire logic [15:0] prog_hi_i,
   output logic [23:0] pc_o,
   output logic [23:0] pc_hi_addr_o,
   output logic [23:0] instr_o,
   // Data requests
   input wire data_space_pkg::x_req_s x_req_i,
   input wire data_space_pkg::agu_cfg_s x_cfg_i,
   input wire data_space_pkg::y_req_s y_req_i,
   input wire data_space_pkg::agu_cfg_s y_cfg_i,
   output logic [15:0] x_ptr_next_o,
   output logic [15:0] y_ptr_next_o,
   output data_space_pkg::rd_rsp_s x_rsp_o,
   output data_space_pkg::rd_rsp_s y_rsp_o,
   // Special function register port
   output logic sfr_rd_o,
   output logic sfr_wr_o,
   output logic [15:0] sfr_addr_o,
   output logic [1:0] sfr_be_o,
   output logic [15:0] sfr_wdata_o,
   input wire logic sfr_hit_i,
   input wire logic [15:0] sfr_rdata_i,
   // Program space visibility port
   output logic psv_rd_o,
   output logic [15:0] psv_addr_o,
   input wire logic [15:0] psv_rdata_i,
   // Exception logic
   output data_space_pkg::addr_err_s addr_err_o
);
   import data_space_pkg::*;

   localparam int RAM_WORDS = RAM_BYTES / 2;
   localparam int RAM_AW = $clog2(RAM_WORDS);
   localparam logic [16:0] RAM_LIMIT = 17'(RAM_BASE) + 17'(RAM_BYTES);

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // ********************************************
   // Program counter and vectors
   // ********************************************
   logic [23:0] vec_addr; // Handler slot address

   // One slot per source, two bytes apart
   assign vec_addr = (vec_alt_i ? VEC_ALT_BASE : VEC_PRI_BASE) +
                     {16'h0000, vec_num_i, 1'b0};

   // Load beats vector beats step; bit 0 is always forced low
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_o <= RESET_PC;
         pc_hi_addr_o <= RESET_PC | 24'h000001;
      end else if (pc_load_i) begin
         pc_o <= {pc_target_i[23:1], 1'b0};
         pc_hi_addr_o <= {pc_target_i[23:1], 1'b1};
      end else if (vec_take_i) begin
         pc_o <= vec_addr;
         pc_hi_addr_o <= vec_addr | 24'h000001;
      end else if (pc_step_i) begin
         pc_o <= pc_o + PC_STEP;
         pc_hi_addr_o <= (pc_o + PC_STEP) | 24'h000001;
      end
   end

   // Upper byte of the odd word is not implemented and is dropped
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         instr_o <= '0;
      end else if (fetch_valid_i) begin
         instr_o <= {prog_hi_i[7:0], prog_lo_i};
      end
   end

   // ********************************************
   // Address generation
   // ********************************************
   logic [15:0] x_agu_ea; // X pointer address
   logic [15:0] x_agu_next;
   logic [15:0] y_agu_ea; // Y pointer address
   logic [15:0] y_agu_next;
   logic [15:0] x_ea; // Final X byte address
   logic x_byte_wr; // Bit-reverse is allowed on X writes only

   assign x_byte_wr = x_req_i.write;

   address_generator u_x_agu (
      .ptr_i (x_req_i.ptr),
      .mode_i (x_req_i.mode),
      .byte_i (x_req_i.byte_op),
      .bitrev_allow_i (x_byte_wr),
      .cfg_i (x_cfg_i),
      .ea_o (x_agu_ea),
      .ptr_next_o (x_agu_next)
   );

   // Y is always a word read, never bit-reversed
   address_generator u_y_agu (
      .ptr_i (y_req_i.ptr),
      .mode_i (y_req_i.mode),
      .byte_i (1'b0),
      .bitrev_allow_i (1'b0),
      .cfg_i (y_cfg_i),
      .ea_o (y_agu_ea),
      .ptr_next_o (y_agu_next)
   );

   // Pick the address source: pointer, full direct, or near field
   always_comb begin
      unique case (x_req_i.src)
         SRC_PTR: x_ea = x_agu_ea;
         SRC_DIRECT: x_ea = x_req_i.direct;
         SRC_NEAR: x_ea = {3'b000, x_req_i.direct[NEAR_W-1:0]};
         default: x_ea = x_agu_ea;
      endcase
   end

   // Pointer write-back, one cycle after the request
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         x_ptr_next_o <= '0;
         y_ptr_next_o <= '0;
      end else begin
         if (x_req_i.valid) begin
            x_ptr_next_o <= x_agu_next;
         end
         if (y_req_i.valid) begin
            y_ptr_next_o <= y_agu_next;
         end
      end
   end

   // ********************************************
   // Region decode and alignment
   // ********************************************
   region_e x_rg; // Where the X address lands
   logic x_mis; // Odd word access on X
   logic y_mis; // Odd word access on Y
   logic y_hit; // Y address inside the Y part of RAM
   logic ram_we;
   logic [1:0] ram_be;
   logic [15:0] wr_data; // Byte data copied onto both lanes
   logic [15:0] x_off; // Offset into RAM
   logic [15:0] y_off;

   // Upper half goes to the window; beyond RAM nothing answers
   always_comb begin
      if (x_ea[PSV_BIT]) begin
         x_rg = RG_PSV;
      end else if (x_ea <= SFR_END) begin
         x_rg = RG_SFR;
      end else if (17'(x_ea) < RAM_LIMIT) begin
         x_rg = RG_RAM;
      end else begin
         x_rg = RG_NONE;
      end
   end

   assign x_mis = x_req_i.valid && !x_req_i.byte_op && x_ea[0];
   assign y_mis = y_req_i.valid && y_agu_ea[0];
   assign y_hit = !y_agu_ea[PSV_BIT] && y_agu_ea >= Y_BASE &&
                  17'(y_agu_ea) < RAM_LIMIT;
   assign x_off = x_ea - RAM_BASE;
   assign y_off = y_agu_ea - RAM_BASE;

   // Even byte is the low lane, odd byte the high lane
   assign ram_be = x_req_i.byte_op ? (x_ea[0] ? 2'b10 : 2'b01) : 2'b11;
   assign wr_data = x_req_i.byte_op ? {2{x_req_i.wdata[7:0]}} : x_req_i.wdata;
   // A misaligned write runs but never reaches memory
   assign ram_we = x_req_i.valid && x_req_i.write && x_rg == RG_RAM && !x_mis;

   // ********************************************
   // Data RAM, X on port A, Y on port B
   // ********************************************
   logic [15:0] ram_a_data;
   logic [15:0] ram_b_data;

   data_ram #(
      .WORDS (RAM_WORDS),
      .AW (RAM_AW)
   ) u_ram (
      .core_clk_i (core_clk_i),
      .a_addr_i (x_off[RAM_AW:1]),
      .b_addr_i (y_off[RAM_AW:1]),
      .we_i (ram_we),
      .w_addr_i (x_off[RAM_AW:1]),
      .be_i (ram_be),
      .wdata_i (wr_data),
      .a_rdata_o (ram_a_data),
      .b_rdata_o (ram_b_data)
   );

   // ********************************************
   // External ports and address error
   // ********************************************
   // Window is read-only; SPECIAL_FUNCTION_REGISTER accesses leave one cycle later
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sfr_rd_o <= 1'b0;
         sfr_wr_o <= 1'b0;
         sfr_addr_o <= '0;
         sfr_be_o <= '0;
         sfr_wdata_o <= '0;
         psv_rd_o <= 1'b0;
         psv_addr_o <= '0;
      end else begin
         sfr_rd_o <= x_req_i.valid && !x_req_i.write && x_rg == RG_SFR;
         sfr_wr_o <= x_req_i.valid && x_req_i.write && x_rg == RG_SFR && !x_mis;
         sfr_addr_o <= {x_ea[15:1], 1'b0};
         sfr_be_o <= ram_be;
         sfr_wdata_o <= wr_data;
         psv_rd_o <= x_req_i.valid && !x_req_i.write && x_rg == RG_PSV;
         psv_addr_o <= {x_ea[15:1], 1'b0};
      end
   end

   // X fault wins when both spaces fault together
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_err_o <= '0;
      end else begin
         addr_err_o.valid <= x_mis || y_mis;
         addr_err_o.write <= x_mis && x_req_i.write;
         addr_err_o.addr <= x_mis ? x_ea : y_agu_ea;
      end
   end

   // ********************************************
   // Read pipeline
   // ********************************************
   logic s1_xv; // X read in flight
   region_e s1_rg;
   logic s1_byte;
   logic s1_lane; // Byte address bit 0
   ext_op_e s1_ext;
   logic [15:0] s1_old; // Register contents before the load
   logic s1_yv;
   logic s1_yhit;
   logic [15:0] x_word; // Raw word from the chosen source
   logic [7:0] x_sel; // Selected byte
   logic [15:0] x_res;

   // Capture the context of each read
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_xv <= 1'b0;
         s1_rg <= RG_NONE;
         s1_byte <= 1'b0;
         s1_lane <= 1'b0;
         s1_ext <= EXT_NONE;
         s1_old <= '0;
         s1_yv <= 1'b0;
         s1_yhit <= 1'b0;
      end else begin
         s1_xv <= x_req_i.valid && !x_req_i.write;
         s1_rg <= x_rg;
         s1_byte <= x_req_i.byte_op;
         s1_lane <= x_ea[0];
         s1_ext <= x_req_i.ext_op;
         s1_old <= x_req_i.wreg_old;
         s1_yv <= y_req_i.valid;
         s1_yhit <= y_hit;
      end
   end

   // Unimplemented places answer zero for byte and word alike
   always_comb begin
      unique case (s1_rg)
         RG_RAM: x_word = ram_a_data;
         RG_SFR: x_word = sfr_hit_i ? sfr_rdata_i : 16'h0000;
         RG_PSV: x_word = psv_rdata_i;
         RG_NONE: x_word = 16'h0000;
         default: x_word = 16'h0000;
      endcase
      x_sel = s1_lane ? x_word[15:8] : x_word[7:0];
      if (!s1_byte) begin
         x_res = x_word;
      end else begin
         unique case (s1_ext)
            EXT_SIGN: x_res = {{8{x_sel[7]}}, x_sel};
            EXT_ZERO: x_res = {8'h00, x_sel};
            default: x_res = {s1_old[15:8], x_sel};
         endcase
      end
   end

   // Both answers land together, two cycles after the request
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         x_rsp_o <= '0;
         y_rsp_o <= '0;
      end else begin
         x_rsp_o.valid <= s1_xv;
         x_rsp_o.data <= x_res;
         y_rsp_o.valid <= s1_yv;
         y_rsp_o.data <= s1_yhit ? ram_b_data : 16'h0000;
      end
   end

   // ********************************************
   // Checks
   // ********************************************
   property p_pc_step;
      pc_step_i && !pc_load_i && !vec_take_i |=> pc_o == $past(pc_o) + PC_STEP;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step by two");

   property p_pc_even;
      !pc_o[0] && pc_hi_addr_o == (pc_o | 24'h000001);
   endproperty
   a_pc_even: assert property (p_pc_even) else $error("pc misaligned");

   property p_vec;
      vec_take_i && !pc_load_i |=> pc_o >= VEC_PRI_BASE && pc_o < VEC_END;
   endproperty
   a_vec: assert property (p_vec) else $error("vector outside table");

   property p_mis_err;
      x_mis |=> addr_err_o.valid && addr_err_o.addr == $past(x_ea)
             && addr_err_o.write == $past(x_req_i.write);
   endproperty
   a_mis_err: assert property (p_mis_err) else $error("missing address error");

   property p_mis_nowr;
      x_mis |-> !ram_we ##1 !sfr_wr_o;
   endproperty
   a_mis_nowr: assert property (p_mis_nowr) else $error("misaligned write hit memory");

   property p_zero;
      x_req_i.valid && !x_req_i.write && !x_req_i.byte_op && x_rg == RG_NONE
      |-> ##2 x_rsp_o.valid && x_rsp_o.data == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("unimplemented read not zero");

   property p_lane;
      ram_we && x_req_i.byte_op |-> $onehot(ram_be) && ram_be[1] == x_ea[0];
   endproperty
   a_lane: assert property (p_lane) else $error("wrong byte lane");

   property p_dual;
      x_req_i.valid && !x_req_i.write && y_req_i.valid |-> ##2 x_rsp_o.valid && y_rsp_o.valid;
   endproperty
   a_dual: assert property (p_dual) else $error("dual read lost");

   property p_byte_keep;
      x_req_i.valid && !x_req_i.write && x_req_i.byte_op && x_req_i.ext_op == EXT_NONE
      |-> ##2 x_rsp_o.data[15:8] == $past(x_req_i.wreg_old[15:8], 2);
   endproperty
   a_byte_keep: assert property (p_byte_keep) else $error("byte load touched high byte");
endmodule : data_space_access_unit
`default_nettype wire

/* File: logic/data_space_pkg.sv */
// Shared constants and carrier types for the data space access unit
package data_space_pkg;
   // ********************************************
   // Widths and steps
   // ********************************************
   localparam int DATA_W = 16;
   localparam int PROG_W = 24;
   localparam int VEC_NUM_W = 7;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [23:0] PC_STEP = 24'h000002;
   // ********************************************
   // Program space map
   // ********************************************
   localparam logic [23:0] RESET_PC = 24'h000000;
   localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
   localparam logic [23:0] VEC_PRI_BASE = 24'h000004;
   localparam logic [23:0] VEC_ALT_BASE = 24'h000100;
   localparam logic [23:0] VEC_END = 24'h000200;
   // ********************************************
   // Data space map
   // ********************************************
   localparam int PSV_BIT = 15;
   localparam int NEAR_W = 13;
   localparam logic [15:0] SFR_END = 16'h07ff;
   localparam logic [15:0] NEAR_END = 16'h1fff;
   localparam logic [15:0] RAM_BASE = 16'h0800;
   localparam int RAM_BYTES_DEF = 16384;
   localparam logic [15:0] Y_BASE_DEF = 16'h2800;
   // ********************************************
   // Enumerations
   // ********************************************
   typedef enum logic [2:0] {
      PM_NONE = 3'h0, PM_POST_INC = 3'h1, PM_POST_DEC = 3'h3,
      PM_PRE_INC = 3'h2, PM_PRE_DEC = 3'h6
   } ptr_mode_e;
   typedef enum logic [1:0] {EXT_NONE = 2'h0, EXT_SIGN = 2'h1, EXT_ZERO = 2'h3} ext_op_e;
   typedef enum logic [1:0] {SRC_PTR = 2'h0, SRC_DIRECT = 2'h1, SRC_NEAR = 2'h3} addr_src_e;
   typedef enum logic [1:0] {RG_NONE = 2'h0, RG_RAM = 2'h1, RG_SFR = 2'h3, RG_PSV = 2'h2} region_e;
   // ********************************************
   // Carriers
   // ********************************************
   typedef struct packed {
      logic mod_en;
      logic [15:0] mod_start;
      logic [15:0] mod_end;
      logic bitrev_en;
      logic [15:0] bitrev_mod;
   } agu_cfg_s;
   typedef struct packed {
      logic valid;
      logic write;
      logic byte_op;
      ext_op_e ext_op;
      addr_src_e src;
      logic [15:0] direct;
      logic [15:0] ptr;
      ptr_mode_e mode;
      logic [15:0] wdata;
      logic [15:0] wreg_old;
   } x_req_s;
   typedef struct packed {
      logic valid;
      logic [15:0] ptr;
      ptr_mode_e mode;
   } y_req_s;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } rd_rsp_s;
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
   } addr_err_s;
endpackage : data_space_pkg

/* File: logic/address_generator.sv */
// Effective address and pointer update for one address generator
`timescale 1ns/1ps
`default_nettype none
module address_generator (
   input wire logic [15:0] ptr_i,
   input wire data_space_pkg::ptr_mode_e mode_i,
   input wire logic byte_i,
   input wire logic bitrev_allow_i,
   input wire data_space_pkg::agu_cfg_s cfg_i,
   output logic [15:0] ea_o,
   output logic [15:0] ptr_next_o
);
   import data_space_pkg::*;

   // Mirror a word index end to end
   function automatic logic [14:0] rev15(input logic [14:0] v);
      logic [14:0] r;
      r = '0;
      for (int i = 0; i < 15; i++) begin
         r[i] = v[14 - i];
      end
      return r;
   endfunction : rev15

   logic [15:0] step; // Byte or word stride
   logic [15:0] inc;
   logic [15:0] dec;
   logic [15:0] inc_m; // Increment after modulo wrap
   logic [15:0] dec_m; // Decrement after modulo wrap
   logic [15:0] brev; // Reverse-carry increment
   logic [15:0] upd;

   // ********************************************
   // Pointer arithmetic
   // ********************************************
   always_comb begin
      step = byte_i ? BYTE_STEP : WORD_STEP;
      inc = ptr_i + step;
      dec = ptr_i - step;
      // Wrap back into the circular buffer at either end
      inc_m = (cfg_i.mod_en && inc > cfg_i.mod_end) ? cfg_i.mod_start : inc;
      dec_m = (cfg_i.mod_en && (dec < cfg_i.mod_start || dec > ptr_i)) ?
              cfg_i.mod_end - step + BYTE_STEP : dec;
      // Carry runs from the top bit down, so reverse, add, reverse back
      brev = {rev15(rev15(ptr_i[15:1]) + rev15(cfg_i.bitrev_mod[15:1])), 1'b0};
      unique case (mode_i)
         PM_NONE: upd = ptr_i;
         PM_POST_INC: upd = (cfg_i.bitrev_en && bitrev_allow_i) ? brev : inc_m;
         PM_PRE_INC: upd = inc_m;
         PM_POST_DEC, PM_PRE_DEC: upd = dec_m;
         default: upd = ptr_i; // Illegal code leaves the pointer alone
      endcase
      ea_o = (mode_i == PM_PRE_INC || mode_i == PM_PRE_DEC) ? upd : ptr_i;
      ptr_next_o = upd;
   end
endmodule : address_generator
`default_nettype wire

/* File: logic/data_ram.sv */
// Two-read one-write data RAM with byte lanes and registered reads
`timescale 1ns/1ps
`default_nettype none
module data_ram #(
   parameter int WORDS = 8192,
   parameter int AW = 13
) (
   input wire logic core_clk_i,
   input wire logic [AW-1:0] a_addr_i,
   input wire logic [AW-1:0] b_addr_i,
   input wire logic we_i,
   input wire logic [AW-1:0] w_addr_i,
   input wire logic [1:0] be_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] a_rdata_o,
   output logic [15:0] b_rdata_o
);
   logic [7:0] a_q [2]; // Port A lane outputs
   logic [7:0] b_q [2]; // Port B lane outputs

   // ********************************************
   // One array per byte lane, shared word decode
   // ********************************************
   for (genvar g = 0; g < 2; g++) begin : g_lane
      logic [7:0] mem [WORDS];
      // Each lane has its own strobe
      always_ff @(posedge core_clk_i) begin
         if (we_i && be_i[g]) begin
            mem[w_addr_i] <= wdata_i[g*8 +: 8];
         end
         a_q[g] <= mem[a_addr_i];
         b_q[g] <= mem[b_addr_i];
      end
   end

   assign a_rdata_o = {a_q[1], a_q[0]};
   assign b_rdata_o = {b_q[1], b_q[0]};
endmodule : data_ram
`default_nettype wire

/* File: test/core_side_model.sv */
// Far-side responder for the register and visibility ports
`timescale 1ns/1ps
`default_nettype none
module core_side_model #(
   parameter logic [15:0] PSV_WORD = 16'hc3a5
) (
   input wire logic core_clk_i,
   input wire logic sfr_rd_i,
   input wire logic sfr_wr_i,
   input wire logic [15:0] sfr_addr_i,
   input wire logic [1:0] sfr_be_i,
   input wire logic [15:0] sfr_wdata_i,
   input wire logic psv_rd_i,
   output logic sfr_hit_o,
   output logic [15:0] sfr_rdata_o,
   output logic [15:0] psv_rdata_o
);
   // Only the first 64 bytes hold registers; the rest of the region is unused
   logic [15:0] regs_reg [32];
   // Junk that changes every cycle, so a stale read is never mistaken for data
   logic [15:0] idle_reg;
   initial begin
      foreach (regs_reg[i]) regs_reg[i] = 16'h0000;
      idle_reg = 16'h0f0f;
   end
   // ********************************************
   // Byte lane writes
   // ********************************************
   always @(posedge core_clk_i) begin
      idle_reg <= ~idle_reg;
      if (sfr_wr_i && sfr_addr_i < 16'h0040) begin
         if (sfr_be_i[0]) regs_reg[sfr_addr_i[5:1]][7:0] <= sfr_wdata_i[7:0];
         if (sfr_be_i[1]) regs_reg[sfr_addr_i[5:1]][15:8] <= sfr_wdata_i[15:8];
      end
   end
   // Unused addresses give no hit, so the unit must return zero
   assign sfr_hit_o = sfr_rd_i && sfr_addr_i < 16'h0040;
   assign sfr_rdata_o = sfr_hit_o ? regs_reg[sfr_addr_i[5:1]] : idle_reg;
   assign psv_rdata_o = psv_rd_i ? PSV_WORD : idle_reg;
endmodule : core_side_model
`default_nettype wire

/* File: test/data_space_access_unit_bench.sv */
// Self-checking bench for the data space access unit
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit_bench;
   import data_space_pkg::*;
   logic core_clk_i, rst_i, pc_step_i, pc_load_i, vec_take_i, vec_alt_i, fetch_valid_i;
   logic [23:0] pc_target_i, pc_o, pc_hi_addr_o, instr_o;
   logic [6:0] vec_num_i;
   logic [15:0] prog_lo_i, prog_hi_i, x_ptr_next_o, y_ptr_next_o, sfr_addr_o, sfr_wdata_o;
   logic [15:0] sfr_rdata_i, psv_addr_o, psv_rdata_i;
   logic sfr_rd_o, sfr_wr_o, sfr_hit_i, psv_rd_o;
   logic [1:0] sfr_be_o;
   x_req_s x_req_i;
   y_req_s y_req_i;
   rd_rsp_s x_rsp_o, y_rsp_o;
   addr_err_s addr_err_o;
   int failures = 0, tests_run = 0, pc = 0;
   logic [7:0] mem [int]; // Reference byte store
   ext_op_e exts [3] = '{EXT_NONE, EXT_SIGN, EXT_ZERO};
   agu_cfg_s x_cfg = '0; // X circular buffer setup
   addr_src_e src_sel = SRC_PTR; // Address source used by the next access
   data_space_access_unit DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .pc_step_i(pc_step_i),
      .pc_load_i(pc_load_i), .pc_target_i(pc_target_i), .vec_take_i(vec_take_i),
      .vec_alt_i(vec_alt_i), .vec_num_i(vec_num_i), .fetch_valid_i(fetch_valid_i),
      .prog_lo_i(prog_lo_i), .prog_hi_i(prog_hi_i), .pc_o(pc_o), .pc_hi_addr_o(pc_hi_addr_o),
      .instr_o(instr_o), .x_req_i(x_req_i), .x_cfg_i(x_cfg), .y_req_i(y_req_i), .y_cfg_i('0),
      .x_ptr_next_o(x_ptr_next_o), .y_ptr_next_o(y_ptr_next_o), .x_rsp_o(x_rsp_o),
      .y_rsp_o(y_rsp_o), .sfr_rd_o(sfr_rd_o), .sfr_wr_o(sfr_wr_o), .sfr_addr_o(sfr_addr_o),
      .sfr_be_o(sfr_be_o), .sfr_wdata_o(sfr_wdata_o), .sfr_hit_i(sfr_hit_i),
      .sfr_rdata_i(sfr_rdata_i), .psv_rd_o(psv_rd_o), .psv_addr_o(psv_addr_o),
      .psv_rdata_i(psv_rdata_i), .addr_err_o(addr_err_o));
   core_side_model far_side (.core_clk_i(core_clk_i), .sfr_rd_i(sfr_rd_o), .sfr_wr_i(sfr_wr_o),
      .sfr_addr_i(sfr_addr_o), .sfr_be_i(sfr_be_o), .sfr_wdata_i(sfr_wdata_o),
      .psv_rd_i(psv_rd_o), .sfr_hit_o(sfr_hit_i), .sfr_rdata_o(sfr_rdata_i),
      .psv_rdata_o(psv_rdata_i));
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // Storage exists in registers below 0x40 and in RAM; the window at 0x8000 and up reads 0xc3a5, everything else reads zero
   function automatic bit kept(input int a);
      return (a >= 'h800 && a < 'h4800) || a < 'h40;
   endfunction : kept
   function automatic logic [15:0] word(input int a);
      if (a >= 'h8000) return 16'hc3a5;
      return {(kept(a|1) && mem.exists(a|1)) ? mem[a|1] : 8'h00,
              (kept(a&~1) && mem.exists(a&~1)) ? mem[a&~1] : 8'h00};
   endfunction : word
   // One X access from the src_sel address source, pointer post-incremented, optionally with a Y read
   task automatic xop(input bit wr, input bit bo, input ext_op_e ext, input int a,
                      input logic [15:0] wd, input logic [15:0] old, input bit yv, input int ya);
      logic [15:0] w;
      logic [15:0] exp;
      logic [7:0] ln;
      logic [15:0] nxt;
      bit mis;
      mis = !bo && a[0];
      nxt = a[15:0] + (bo ? BYTE_STEP : WORD_STEP);
      if (x_cfg.mod_en && nxt > x_cfg.mod_end) nxt = x_cfg.mod_start;
      w = word(a & ~1);
      ln = a[0] ? w[15:8] : w[7:0];
      exp = !bo ? w : ext == EXT_SIGN ? {{8{ln[7]}}, ln} : ext == EXT_ZERO ? {8'h00, ln} :
            {old[15:8], ln};
      x_req_i = '0;
      x_req_i.valid = 1'b1;
      x_req_i.write = wr;
      x_req_i.byte_op = bo;
      x_req_i.ext_op = ext;
      x_req_i.src = src_sel;
      x_req_i.direct = a[15:0] | (src_sel == SRC_NEAR ? 16'he000 : 16'h0000);
      x_req_i.ptr = a[15:0];
      x_req_i.mode = PM_POST_INC;
      x_req_i.wdata = wd;
      x_req_i.wreg_old = old;
      y_req_i = '{valid: yv, ptr: ya[15:0], mode: PM_POST_INC};
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      x_req_i.valid = 1'b0;
      y_req_i.valid = 1'b0;
      check("addr_err", {addr_err_o.valid, addr_err_o.write}, {mis, mis & wr});
      if (mis) check("err_addr", addr_err_o.addr, a[15:0]);
      else check("x_ptr", x_ptr_next_o, nxt);
      if (yv) check("y_ptr", y_ptr_next_o, ya[15:0] + 16'h0002);
      if (a < 'h800) check("sfr_req", {sfr_rd_o, sfr_wr_o, sfr_be_o, sfr_addr_o},
                           {!wr, wr && !mis, bo ? {a[0], !a[0]} : 2'b11, a[15:1], 1'b0});
      if (a >= 'h8000) check("psv_req", {psv_rd_o, psv_addr_o}, {!wr, a[15:1], 1'b0});
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      check("err_pulse", addr_err_o.valid, 1'b0);
      check("x_valid", x_rsp_o.valid, !wr);
      if (!wr) check("x_data", x_rsp_o.data, exp);
      if (yv) check("y_data", {y_rsp_o.valid, y_rsp_o.data}, {1'b1, word(ya)});
      if (wr && !mis && kept(a)) mem[a] = wd[7:0];
      if (wr && !mis && !bo && kept(a)) mem[a+1] = wd[15:8];
   endtask : xop
   task automatic pc_cmd(input bit st, input bit ld, input bit vt, input bit alt, input int n,
                         input int tgt);
      {pc_step_i, pc_load_i, vec_take_i, vec_alt_i} = {st, ld, vt, alt};
      vec_num_i = n[6:0];
      pc_target_i = tgt[23:0];
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      {pc_step_i, pc_load_i, vec_take_i} = 3'h0;
      if (ld) pc = tgt & ~1;
      else if (vt) pc = (alt ? 'h100 : 'h4) + 2 * n;
      else if (st) pc += 2;
      check("pc", {pc_o, pc_hi_addr_o}, {pc[23:0], pc[23:0] | 24'h000001});
   endtask : pc_cmd
   initial begin
      #2000000;
      failures++;
      complete_run();
   end
   initial begin
      int a;
      logic [15:0] d;
      {rst_i, pc_step_i, pc_load_i, vec_take_i, vec_alt_i, fetch_valid_i} = 6'h20;
      {pc_target_i, vec_num_i, prog_lo_i, prog_hi_i} = '0;
      x_req_i = '0;
      y_req_i = '0;
      void'($urandom(32'h684d));
      repeat (6) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_i = 1'b0;
      check("reset_pc", {pc_o, pc_hi_addr_o}, {24'h000000, 24'h000001});
      pc_cmd(1, 0, 0, 0, 0, 0);
      pc_cmd(1, 0, 0, 0, 0, 0);
      pc_cmd(1, 1, 1, 0, 3, 'h123457);
      for (int i = 0; i < 4; i++) pc_cmd(1, 0, 1, i[0], i * 41, 0);
      prog_lo_i = $urandom;
      prog_hi_i = $urandom;
      fetch_valid_i = 1'b1;
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      fetch_valid_i = 1'b0;
      check("instr", instr_o, {prog_hi_i[7:0], prog_lo_i});
      for (int i = 0; i < 12; i++) begin
         a = 'h800 + 2 * ($urandom % 8192);
         d = $urandom;
         xop(1, 0, EXT_NONE, a, d, 0, 0, 0);
         xop(0, 1, exts[i % 3], a + i % 2, 0, ~d, 0, 0);
         xop(1, 1, EXT_NONE, a + 1 - i % 2, ~d, 0, 0, 0);
         xop(0, 0, EXT_NONE, a, 0, 0, 1, 'h2800 + 2 * ($urandom % 4096));
      end
      xop(1, 0, EXT_NONE, 'h0020, 16'h81c3, 0, 0, 0);
      xop(1, 1, EXT_NONE, 'h0021, 16'h0057, 0, 0, 0);
      xop(0, 0, EXT_NONE, 'h0020, 0, 0, 0, 0);
      xop(0, 1, EXT_SIGN, 'h0400, 0, 16'hffff, 0, 0);
      xop(0, 0, EXT_NONE, 'h7000, 0, 0, 0, 0);
      xop(0, 0, EXT_NONE, 'h8000, 0, 0, 0, 0);
      xop(1, 0, EXT_NONE, 'h0803, 16'h1234, 0, 0, 0);
      xop(0, 0, EXT_NONE, 'h0803, 0, 0, 0, 0);
      xop(0, 0, EXT_NONE, 'h0802, 0, 0, 0, 0);
      src_sel = SRC_NEAR;
      xop(0, 0, EXT_NONE, 'h0020, 0, 0, 0, 0);
      src_sel = SRC_DIRECT;
      xop(0, 0, EXT_NONE, 'h8000, 0, 0, 0, 0);
      src_sel = SRC_PTR;
      x_cfg = '{mod_en: 1'b1, mod_start: 16'h0900, mod_end: 16'h090f,
                bitrev_en: 1'b0, bitrev_mod: 16'h0000};
      xop(0, 0, EXT_NONE, 'h090e, 0, 0, 0, 0);
      complete_run();
   end
endmodule : data_space_access_unit_bench
`default_nettype wire
